// ===== hw/ifsb_defines.vh
// constants for the interrupt flag status bank: register offsets, bit masks,
// reset values and apb widths. included by the bank module only.
`ifndef IFSB_DEFINES_VH
`define IFSB_DEFINES_VH

// ----------------------------------------------------------------------------
// apb shape
// ----------------------------------------------------------------------------
`define IFSB_ADDR_W       8
`define IFSB_DATA_W       32
`define IFSB_WORD_W       16

// ----------------------------------------------------------------------------
// byte offsets: flag words, then companion enable words
// ----------------------------------------------------------------------------
`define IFSB_OFS_FLAGS_B  8'h00
`define IFSB_OFS_FLAGS_C  8'h04
`define IFSB_OFS_FLAGS_D  8'h08
`define IFSB_OFS_FLAGS_E  8'h0c
`define IFSB_OFS_ENA_B    8'h10
`define IFSB_OFS_ENA_C    8'h14
`define IFSB_OFS_ENA_D    8'h18
`define IFSB_OFS_ENA_E    8'h1c

// ----------------------------------------------------------------------------
// implemented bits of each word (enable words share the layout)
// ----------------------------------------------------------------------------
`define IFSB_MASK_B       16'hfe1f
`define IFSB_MASK_C       16'h22e3
`define IFSB_MASK_D       16'h4006
`define IFSB_MASK_E       16'h010e

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define IFSB_RST_WORD     16'h0000

// ----------------------------------------------------------------------------
// bit positions, second word
// ----------------------------------------------------------------------------
`define IFSB_B_UART_TX    15
`define IFSB_B_UART_RX    14
`define IFSB_B_EXT_C      13
`define IFSB_B_TIMER_E    12
`define IFSB_B_TIMER_D    11
`define IFSB_B_CMP_D      10
`define IFSB_B_CMP_C      9
`define IFSB_B_EXT_B      4
`define IFSB_B_CHANGE     3
`define IFSB_B_COMPARATOR 2
`define IFSB_B_I2CA_MST   1
`define IFSB_B_I2CA_SLV   0

// ----------------------------------------------------------------------------
// bit positions, third word
// ----------------------------------------------------------------------------
`define IFSB_C_PARALLEL   13
`define IFSB_C_CMP_E      9
`define IFSB_C_CAP_E      7
`define IFSB_C_CAP_D      6
`define IFSB_C_CAP_C      5
`define IFSB_C_SPI_EVT    1
`define IFSB_C_SPI_FLT    0

// ----------------------------------------------------------------------------
// bit positions, fourth and fifth words
// ----------------------------------------------------------------------------
`define IFSB_D_CALENDAR   14
`define IFSB_D_I2CB_MST   2
`define IFSB_D_I2CB_SLV   1
`define IFSB_E_LOW_VOLT   8
`define IFSB_E_CRC        3
`define IFSB_E_UARTB_ERR  2
`define IFSB_E_UARTA_ERR  1

`endif

// ===== hw/ifsb_flag_bank.v
// interrupt flag status bank: four sticky flag words with companion enables,
// reached over apb. assumes request inputs come from logic on pclk.
`timescale 1ns/1ps
`include "ifsb_defines.vh"

// Functional notes
// - a flag reads 1 once its source requested, 0 while none is recorded.
// - every implemented flag bit is read/write and resets to 0.
// - unimplemented bit positions of every flag word always read 0.
// - second word bit 15 uart b transmit, bit 14 uart b receive.
// - second word bit 13 external pin c.
// - second word bit 12 timer e, bit 11 timer d.
// - second word bit 10 compare d, bit 9 compare c.
// - second word bit 4 pin b, bit 3 change notice, bit 2 comparator.
// - second word bit 1 i2c a master, bit 0 i2c a slave.
// - third word bit 13 parallel port; bits 15-14, 12-10, 8, 4-2 read 0.
// - third word bit 9 compare e.
// - third word bits 7, 6, 5 capture e, d, c.
// - third word bit 1 spi b event, bit 0 spi b fault.
// - fourth word bit 14 calendar clock; bits 15 and 0 read 0.
// - fourth word bit 2 i2c b master, bit 1 i2c b slave.
// - fifth word bit 8 low-voltage detect.
// - fifth word bit 3 crc engine; bits 7-4 read 0.
// - fifth word bit 2 uart b error, bit 1 uart a error; bit 0 reads 0.
// - a flag goes to priority logic only while its enable bit is 1.
module ifsb_flag_bank (
  // clock and reset
  input  wire                      pclk,
  input  wire                      presetn,

  // apb slave
  input  wire                      psel,
  input  wire                      penable,
  input  wire                      pwrite,
  input  wire [`IFSB_ADDR_W-1:0]   paddr,
  input  wire [`IFSB_DATA_W-1:0]   pwdata,
  input  wire [3:0]                pstrb,
  output reg  [`IFSB_DATA_W-1:0]   prdata,
  output reg                       pready,
  output reg                       pslverr,

  // source requests, second word
  input  wire                      uart_b_tx_req,
  input  wire                      uart_b_rx_req,
  input  wire                      ext_pin_c_req,
  input  wire                      timer_e_req,
  input  wire                      timer_d_req,
  input  wire                      compare_d_req,
  input  wire                      compare_c_req,
  input  wire                      ext_pin_b_req,
  input  wire                      change_notice_req,
  input  wire                      comparator_req,
  input  wire                      i2c_a_master_req,
  input  wire                      i2c_a_slave_req,

  // source requests, third word
  input  wire                      parallel_port_req,
  input  wire                      compare_e_req,
  input  wire                      capture_e_req,
  input  wire                      capture_d_req,
  input  wire                      capture_c_req,
  input  wire                      spi_b_event_req,
  input  wire                      spi_b_fault_req,

  // source requests, fourth and fifth words
  input  wire                      calendar_clock_req,
  input  wire                      i2c_b_master_req,
  input  wire                      i2c_b_slave_req,
  input  wire                      low_voltage_req,
  input  wire                      crc_engine_req,
  input  wire                      uart_b_error_req,
  input  wire                      uart_a_error_req,

  // latched flags, second word
  output wire                      uart_b_tx_flag,
  output wire                      uart_b_rx_flag,
  output wire                      ext_pin_c_flag,
  output wire                      timer_e_flag,
  output wire                      timer_d_flag,
  output wire                      compare_d_flag,
  output wire                      compare_c_flag,
  output wire                      ext_pin_b_flag,
  output wire                      change_notice_flag,
  output wire                      comparator_flag,
  output wire                      i2c_a_master_flag,
  output wire                      i2c_a_slave_flag,

  // latched flags, third word
  output wire                      parallel_port_flag,
  output wire                      compare_e_flag,
  output wire                      capture_e_flag,
  output wire                      capture_d_flag,
  output wire                      capture_c_flag,
  output wire                      spi_b_event_flag,
  output wire                      spi_b_fault_flag,

  // latched flags, fourth word
  output wire                      calendar_clock_flag,
  output wire                      i2c_b_master_flag,
  output wire                      i2c_b_slave_flag,

  // latched flags, fifth word
  output wire                      low_voltage_flag,
  output wire                      crc_engine_flag,
  output wire                      uart_b_error_flag,
  output wire                      uart_a_error_flag,

  // enabled requests toward priority logic, one word each
  output wire [`IFSB_WORD_W-1:0]   irq_pending_b,
  output wire [`IFSB_WORD_W-1:0]   irq_pending_c,
  output wire [`IFSB_WORD_W-1:0]   irq_pending_d,
  output wire [`IFSB_WORD_W-1:0]   irq_pending_e
);

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  // register map, one 16-bit word per aligned 32-bit slot:
  //   0x00 .. 0x0c  flag words b, c, d, e
  //   0x10 .. 0x1c  enable words b, c, d, e
  //   anything else is refused with pslverr and never written
  // result: [3] hit, [2] enable bank, [1:0] word index
  function [3:0] ifsb_decode;
    input [`IFSB_ADDR_W-1:0] addr;
    begin
      case (addr)
        `IFSB_OFS_FLAGS_B: ifsb_decode = 4'h8;
        `IFSB_OFS_FLAGS_C: ifsb_decode = 4'h9;
        `IFSB_OFS_FLAGS_D: ifsb_decode = 4'ha;
        `IFSB_OFS_FLAGS_E: ifsb_decode = 4'hb;
        `IFSB_OFS_ENA_B:   ifsb_decode = 4'hc;
        `IFSB_OFS_ENA_C:   ifsb_decode = 4'hd;
        `IFSB_OFS_ENA_D:   ifsb_decode = 4'he;
        `IFSB_OFS_ENA_E:   ifsb_decode = 4'hf;
        default:           ifsb_decode = 4'h0;
      endcase
    end
  endfunction

  // implemented bits of a word; the other positions never store a value
  function [`IFSB_WORD_W-1:0] ifsb_mask;
    input [1:0] idx;
    begin
      case (idx)
        2'h0:    ifsb_mask = `IFSB_MASK_B;
        2'h1:    ifsb_mask = `IFSB_MASK_C;
        2'h2:    ifsb_mask = `IFSB_MASK_D;
        default: ifsb_mask = `IFSB_MASK_E;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // request words
  // --------------------------------------------------------------------------
  // requests come from logic on pclk and are not synchronised here; a source
  // in another clock domain must be brought onto pclk before it reaches us
  // a request is taken on every edge at which it is high, so a level held
  // for many cycles and a one-cycle pulse leave the same flag behind
  wire [`IFSB_WORD_W-1:0] req_word [0:3];
  wire [3:0]              dec_now;
  wire                    acc_write;
  wire [`IFSB_WORD_W-1:0] lane_mask;

  // second word
  assign req_word[0] = {uart_b_tx_req,
                        uart_b_rx_req,
                        ext_pin_c_req,
                        timer_e_req,
                        timer_d_req,
                        compare_d_req,
                        compare_c_req,
                        4'h0,
                        ext_pin_b_req,
                        change_notice_req,
                        comparator_req,
                        i2c_a_master_req,
                        i2c_a_slave_req};

  // third word
  assign req_word[1] = {2'h0,
                        parallel_port_req,
                        3'h0,
                        compare_e_req,
                        1'b0,
                        capture_e_req,
                        capture_d_req,
                        capture_c_req,
                        3'h0,
                        spi_b_event_req,
                        spi_b_fault_req};

  // fourth word
  assign req_word[2] = {1'b0,
                        calendar_clock_req,
                        11'h000,
                        i2c_b_master_req,
                        i2c_b_slave_req,
                        1'b0};

  // fifth word
  assign req_word[3] = {7'h00,
                        low_voltage_req,
                        4'h0,
                        crc_engine_req,
                        uart_b_error_req,
                        uart_a_error_req,
                        1'b0};

  assign dec_now   = ifsb_decode(paddr);
  // pready is only high in the access cycle, so this fires once per transfer
  assign acc_write = psel & penable & pready & pwrite & dec_now[3];
  // byte strobes gate both halves of a write; with pstrb[1] low bits 15:8
  // stay as they are, so software may clear one byte of flags on its own
  assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  // --------------------------------------------------------------------------
  // flag and enable words
  // --------------------------------------------------------------------------
  reg  [`IFSB_WORD_W-1:0] flag_word [0:3];
  reg  [`IFSB_WORD_W-1:0] ena_word  [0:3];
  reg  [`IFSB_WORD_W-1:0] pend_word [0:3];

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_word
      localparam [1:0] word_idx = g;
      wire                    wr_flag;
      wire                    wr_ena;
      wire [`IFSB_WORD_W-1:0] wr_val;
      wire [`IFSB_WORD_W-1:0] next_flag;
      wire [`IFSB_WORD_W-1:0] next_ena;

      assign wr_flag = acc_write & ~dec_now[2] & (dec_now[1:0] == word_idx);
      assign wr_ena  = acc_write &  dec_now[2] & (dec_now[1:0] == word_idx);
      assign wr_val  = pwdata[`IFSB_WORD_W-1:0] & lane_mask;

      // written 1 sets, written 0 clears; a request this cycle still wins.
      // clear and set sit in one expression on purpose: a request landing
      // in the clearing write's access cycle is never lost, which software
      // relies on when it clears a flag on its way out of a handler
      assign next_flag = ((wr_flag ? ((flag_word[g] & ~lane_mask) | wr_val)
                                   : flag_word[g])
                          | req_word[g]) & ifsb_mask(word_idx);
      assign next_ena  = (wr_ena ? ((ena_word[g] & ~lane_mask) | wr_val)
                                 : ena_word[g]) & ifsb_mask(word_idx);

      // flag word: sticky, cleared only by reset or a software write of 0
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flag_word[g] <= `IFSB_RST_WORD;
        end else begin
          flag_word[g] <= next_flag;
        end
      end

      // enable word: plain read/write, same implemented bits as the flags
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ena_word[g] <= `IFSB_RST_WORD;
        end else begin
          ena_word[g] <= next_ena;
        end
      end

      // pending word: built from the next values so it lines up with the
      // flag outputs instead of trailing them by a cycle
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pend_word[g] <= `IFSB_RST_WORD;
        end else begin
          pend_word[g] <= next_flag & next_ena;
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // apb response
  // --------------------------------------------------------------------------
  // every transfer gets exactly one access cycle: no wait states, so a master
  // never stalls here; an unmapped address answers with pslverr and no write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel & ~penable) begin
      pready  <= 1'b1;
      pslverr <= ~dec_now[3];
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // read data is captured in the setup cycle, so a request landing in the
  // access cycle shows on the next read, never half-way through this one
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= {`IFSB_DATA_W{1'b0}};
    end else if (psel & ~penable) begin
      if (!dec_now[3] || pwrite) begin
        prdata <= {`IFSB_DATA_W{1'b0}};
      end else if (dec_now[2]) begin
        prdata <= {16'h0000, ena_word[dec_now[1:0]]};
      end else begin
        prdata <= {16'h0000, flag_word[dec_now[1:0]]};
      end
    end
  end

  // --------------------------------------------------------------------------
  // flag outputs
  // --------------------------------------------------------------------------
  // every flag and pending output is a register bit, never a gate behind one
  // second word
  assign uart_b_tx_flag      = flag_word[0][`IFSB_B_UART_TX];
  assign uart_b_rx_flag      = flag_word[0][`IFSB_B_UART_RX];

  assign ext_pin_c_flag      = flag_word[0][`IFSB_B_EXT_C];

  assign timer_e_flag        = flag_word[0][`IFSB_B_TIMER_E];
  assign timer_d_flag        = flag_word[0][`IFSB_B_TIMER_D];

  assign compare_d_flag      = flag_word[0][`IFSB_B_CMP_D];
  assign compare_c_flag      = flag_word[0][`IFSB_B_CMP_C];

  assign ext_pin_b_flag      = flag_word[0][`IFSB_B_EXT_B];
  assign change_notice_flag  = flag_word[0][`IFSB_B_CHANGE];
  assign comparator_flag     = flag_word[0][`IFSB_B_COMPARATOR];

  assign i2c_a_master_flag   = flag_word[0][`IFSB_B_I2CA_MST];
  assign i2c_a_slave_flag    = flag_word[0][`IFSB_B_I2CA_SLV];

  // third word
  assign parallel_port_flag  = flag_word[1][`IFSB_C_PARALLEL];

  assign compare_e_flag      = flag_word[1][`IFSB_C_CMP_E];

  assign capture_e_flag      = flag_word[1][`IFSB_C_CAP_E];
  assign capture_d_flag      = flag_word[1][`IFSB_C_CAP_D];
  assign capture_c_flag      = flag_word[1][`IFSB_C_CAP_C];

  assign spi_b_event_flag    = flag_word[1][`IFSB_C_SPI_EVT];
  assign spi_b_fault_flag    = flag_word[1][`IFSB_C_SPI_FLT];

  // fourth word
  assign calendar_clock_flag = flag_word[2][`IFSB_D_CALENDAR];

  assign i2c_b_master_flag   = flag_word[2][`IFSB_D_I2CB_MST];
  assign i2c_b_slave_flag    = flag_word[2][`IFSB_D_I2CB_SLV];

  // fifth word
  assign low_voltage_flag    = flag_word[3][`IFSB_E_LOW_VOLT];

  assign crc_engine_flag     = flag_word[3][`IFSB_E_CRC];

  assign uart_b_error_flag   = flag_word[3][`IFSB_E_UARTB_ERR];
  assign uart_a_error_flag   = flag_word[3][`IFSB_E_UARTA_ERR];

  // pending words toward the priority logic; the enable gates what is
  // forwarded but never the flag itself, so a disabled source still shows
  // its flag to software polling the flag words
  assign irq_pending_b = pend_word[0];
  assign irq_pending_c = pend_word[1];
  assign irq_pending_d = pend_word[2];
  assign irq_pending_e = pend_word[3];

endmodule // ifsb_flag_bank

// ===== test/ifsb_flag_bank_checker.sv
// assertion checker for the flag bank, bound onto its apb and source ports.
// assumes one pclk domain and an active-low asynchronous presetn.
`timescale 1ns/1ps
module ifsb_flag_bank_checker (
  // clock, reset and apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  // watched sources, flags and pending word
  input wire logic        uart_b_tx_req,
  input wire logic        uart_b_tx_flag,
  input wire logic        i2c_a_slave_req,
  input wire logic        i2c_a_slave_flag,
  input wire logic        parallel_port_req,
  input wire logic        parallel_port_flag,
  input wire logic        calendar_clock_req,
  input wire logic        calendar_clock_flag,
  input wire logic        low_voltage_req,
  input wire logic        low_voltage_flag,
  input wire logic        crc_engine_req,
  input wire logic        crc_engine_flag,
  input wire logic [15:0] irq_pending_b
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // write access to the second flag word, the edge at which it lands
  wire wr_b = psel && penable && pwrite && paddr == 8'h00;
  wire rd_ok = pready && !pwrite;

  property p_tx_set; uart_b_tx_req |=> uart_b_tx_flag; endproperty
  a_tx_set: assert property (p_tx_set) else $error("tx flag not set");
  property p_pmp_set; parallel_port_req |=> parallel_port_flag; endproperty
  a_pmp_set: assert property (p_pmp_set) else $error("parallel flag not set");
  property p_cal_set; calendar_clock_req |=> calendar_clock_flag; endproperty
  a_cal_set: assert property (p_cal_set) else $error("calendar flag not set");
  property p_lv_set; low_voltage_req |=> low_voltage_flag; endproperty
  a_lv_set: assert property (p_lv_set) else $error("low voltage flag not set");
  property p_crc_set; crc_engine_req |=> crc_engine_flag; endproperty
  a_crc_set: assert property (p_crc_set) else $error("crc flag not set");
  property p_sticky; uart_b_tx_flag && !(wr_b && pstrb[1] && !pwdata[15]) |=> uart_b_tx_flag; endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without clear");
  property p_req_wins; wr_b && uart_b_tx_req |=> uart_b_tx_flag; endproperty
  a_req_wins: assert property (p_req_wins) else $error("clear beat request");
  property p_set_cause;
    $rose(i2c_a_slave_flag) |-> $past(i2c_a_slave_req) || $past(wr_b && pstrb[0] && pwdata[0]);
  endproperty
  a_set_cause: assert property (p_set_cause) else $error("flag set without cause");
  property p_mask_c; rd_ok && paddr == 8'h04 |-> (prdata & ~32'h000022e3) == 32'h0; endproperty
  a_mask_c: assert property (p_mask_c) else $error("third word spare bit set");
  property p_pend; irq_pending_b[15] |-> uart_b_tx_flag; endproperty
  a_pend: assert property (p_pend) else $error("pending without flag");
  c_race: cover property (wr_b && uart_b_tx_req);
  c_pend: cover property (irq_pending_b[15]);
  c_clear: cover property ($fell(uart_b_tx_flag));
endmodule // ifsb_flag_bank_checker

bind ifsb_flag_bank ifsb_flag_bank_checker u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .uart_b_tx_req(uart_b_tx_req),
  .uart_b_tx_flag(uart_b_tx_flag), .i2c_a_slave_req(i2c_a_slave_req), .i2c_a_slave_flag(i2c_a_slave_flag),
  .parallel_port_req(parallel_port_req), .parallel_port_flag(parallel_port_flag),
  .calendar_clock_req(calendar_clock_req), .calendar_clock_flag(calendar_clock_flag),
  .low_voltage_req(low_voltage_req), .low_voltage_flag(low_voltage_flag),
  .crc_engine_req(crc_engine_req), .crc_engine_flag(crc_engine_flag), .irq_pending_b(irq_pending_b));

// ===== test/ifsb_src_model.sv
// peripheral source model: request lines of all four flag words.
// assumes the bench calls pulse from its procedural flow after an edge.
`timescale 1ns/1ps
module ifsb_src_model (
  // clock
  input  wire logic        pclk,
  // requests, word b in 15:0 up to word e in 63:48
  output logic      [63:0] rq
);
  initial rq = 64'h0;
  // one-cycle pulse after dly edges, changed just after an edge
  task pulse(input logic [63:0] v, input integer dly);
    begin
      repeat (dly) @(posedge pclk);
      rq <= v;
      @(posedge pclk);
      rq <= 64'h0;
    end
  endtask
endmodule // ifsb_src_model

// ===== test/interrupt_flag_status_bank_tb.sv
// self-checking bench for the flag bank over apb with a source model.
// assumes the bank answers each apb access after one wait-free setup.
`timescale 1ns/1ps
module interrupt_flag_status_bank_tb;
  localparam [63:0] mask = 64'h010e_4006_22e3_fe1f;
  logic        pclk, presetn, psel, penable, pwrite, pslverr, pready;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb;
  logic        err;
  wire  [63:0] rq, fl;
  wire  [15:0] pb, pc, pd, pe;
  integer      failures, n_compared, cycles, i;

  ifsb_src_model src (.pclk(pclk), .rq(rq));
  ifsb_flag_bank uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .uart_b_tx_req(rq[15]), .uart_b_tx_flag(fl[15]), .uart_b_rx_req(rq[14]), .uart_b_rx_flag(fl[14]),
    .ext_pin_c_req(rq[13]), .ext_pin_c_flag(fl[13]), .timer_e_req(rq[12]), .timer_e_flag(fl[12]),
    .timer_d_req(rq[11]), .timer_d_flag(fl[11]), .compare_d_req(rq[10]), .compare_d_flag(fl[10]),
    .compare_c_req(rq[9]), .compare_c_flag(fl[9]), .ext_pin_b_req(rq[4]), .ext_pin_b_flag(fl[4]),
    .change_notice_req(rq[3]), .change_notice_flag(fl[3]), .comparator_req(rq[2]), .comparator_flag(fl[2]),
    .i2c_a_master_req(rq[1]), .i2c_a_master_flag(fl[1]), .i2c_a_slave_req(rq[0]), .i2c_a_slave_flag(fl[0]),
    .parallel_port_req(rq[29]), .parallel_port_flag(fl[29]), .compare_e_req(rq[25]), .compare_e_flag(fl[25]),
    .capture_e_req(rq[23]), .capture_e_flag(fl[23]), .capture_d_req(rq[22]), .capture_d_flag(fl[22]),
    .capture_c_req(rq[21]), .capture_c_flag(fl[21]), .spi_b_event_req(rq[17]), .spi_b_event_flag(fl[17]),
    .spi_b_fault_req(rq[16]), .spi_b_fault_flag(fl[16]), .calendar_clock_req(rq[46]), .calendar_clock_flag(fl[46]),
    .i2c_b_master_req(rq[34]), .i2c_b_master_flag(fl[34]), .i2c_b_slave_req(rq[33]), .i2c_b_slave_flag(fl[33]),
    .low_voltage_req(rq[56]), .low_voltage_flag(fl[56]), .crc_engine_req(rq[51]), .crc_engine_flag(fl[51]),
    .uart_b_error_req(rq[50]), .uart_b_error_flag(fl[50]), .uart_a_error_req(rq[49]), .uart_a_error_flag(fl[49]),
    .irq_pending_b(pb), .irq_pending_c(pc), .irq_pending_d(pd), .irq_pending_e(pe));

  task complete_run;
    if (failures == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; waits an edge first so psel is never driven twice in a step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    // sample the access cycle while it stands, release after its closing edge
    @(negedge pclk);
    while (pready !== 1'b1) @(negedge pclk);
    q = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check({q, err}, {exp, 1'b0});
  endtask

  task t_reset;
    for (i = 0; i < 8; i = i + 1) rd(8'(i * 4), 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check({q, err}, {32'h0, 1'b1});
  endtask
  task t_each_source;
    for (i = 0; i < 64; i = i + 1) if (mask[i]) begin
      src.pulse(64'h1 << i, 1);
      @(negedge pclk);
      check(fl & mask, 64'h1 << i);
      rd({2'b0, 4'(i / 16), 2'b0}, 32'h1 << (i % 16));
      apb(1'b1, {2'b0, 4'(i / 16), 2'b0}, 32'h0);
      @(negedge pclk);
      check(fl & mask, 64'h0);
    end
  endtask
  task t_soft_set;
    for (i = 0; i < 4; i = i + 1) begin
      apb(1'b1, 8'(i * 4), 32'hffffffff);
      rd(8'(i * 4), 32'(mask[i*16 +: 16]));
      apb(1'b1, 8'(i * 4), 32'h0);
      rd(8'(i * 4), 32'h0);
    end
  endtask
  task t_race;
    apb(1'b1, 8'h00, 32'h3);
    fork
      apb(1'b1, 8'h00, 32'h0);
      src.pulse(64'h8000, 2);
    join
    rd(8'h00, 32'h8000);
    apb(1'b1, 8'h00, 32'h0);
  endtask
  task t_enable;
    apb(1'b1, 8'h10, 32'hffff);
    rd(8'h10, 32'hfe1f);
    apb(1'b1, 8'h00, 32'h8011);
    @(negedge pclk);
    check(pb, 16'h8011);
    apb(1'b1, 8'h10, 32'h0);
    @(negedge pclk);
    check(pb, 16'h0);
    rd(8'h00, 32'h8011);
    apb(1'b1, 8'h00, 32'h0);
    for (i = 1; i < 4; i = i + 1) begin
      apb(1'b1, 8'(16 + i * 4), 32'hffff);
      apb(1'b1, 8'(i * 4), 32'hffff);
    end
    @(negedge pclk);
    check({pe, pd, pc, pb}, mask & ~64'hffff);
    for (i = 1; i < 8; i = i + 1) apb(1'b1, 8'(i * 4), 32'h0);
  endtask
  task t_mid_reset;
    apb(1'b1, 8'h00, 32'hffff);
    @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    check(fl & mask, 64'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 32'h0);
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // hang guard: the whole sequence needs a few hundred cycles
  always @(posedge pclk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      complete_run;
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    failures = 0;
    n_compared = 0;
    cycles = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_each_source;
    t_soft_set;
    t_race;
    t_enable;
    t_mid_reset;
    complete_run;
  end
endmodule // interrupt_flag_status_bank_tb
